// ==== rtl/port_alternate_function_override.sv ====
`timescale 1ns/100ps
`include "port_override_defs.svh"

module port_alternate_function_override
   import port_override_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   // Shared control
   input wire logic global_pullup_disable,
   input wire logic ext_mem_enable,
   input wire logic address_active,
   input wire logic write_strobe,
   input wire logic [`MASK_W-1:0] address_mask_field,
   // Memory interface data
   input wire logic [`PA_PINS-1:0] addr_low,
   input wire logic [`PA_PINS-1:0] data_out,
   input wire logic [`PC_PINS-1:0] addr_high,
   // Port A low nibble
   input wire logic [`PA_PINS-1:0] dir_a,
   input wire logic [`PA_PINS-1:0] out_a,
   input wire logic [`PA_PINS-1:0] pad_in_a,
   output logic [`PA_PINS-1:0] pad_out_a,
   output logic [`PA_PINS-1:0] pad_oe_n_a,
   output logic [`PA_PINS-1:0] pullup_a,
   output logic [`PA_PINS-1:0] data_in,
   // Port B
   input wire logic serial_if_enable,
   input wire logic serial_master_select,
   input wire logic serial_clock_out,
   input wire logic master_data_out,
   input wire logic slave_data_out,
   input wire logic compare_out_enable,
   input wire logic timer_zero_compare_out,
   input wire logic [`PB_PINS-1:0] dir_b,
   input wire logic [`PB_PINS-1:0] out_b,
   input wire logic [`PB_PINS-1:0] pad_in_b,
   output logic [`PB_PINS-1:0] pad_out_b,
   output logic [`PB_PINS-1:0] pad_oe_n_b,
   output logic [`PB_PINS-1:0] pullup_b,
   output logic serial_clock_in,
   output logic master_data_in,
   output logic slave_data_in,
   output logic slave_select_in,
   output logic serial_slave_active,
   output logic timer_one_count_in,
   output logic timer_zero_count_in,
   // Port C
   input wire logic [`PC_PINS-1:0] dir_c,
   input wire logic [`PC_PINS-1:0] out_c,
   input wire logic [`PC_PINS-1:0] pad_in_c,
   output logic [`PC_PINS-1:0] pad_out_c,
   output logic [`PC_PINS-1:0] pad_oe_n_c,
   output logic [`PC_PINS-1:0] pullup_c
);

   // Upper address threshold for port C pin index: 1..7, the low two share 7
   function automatic logic [`MASK_W:0] mask_threshold(input int idx);
      logic [`MASK_W:0] t;
      t = {1'b0, `MASK_TOP} - (`MASK_W+1)'(idx) + (`MASK_W+1)'(1);
      if (t > {1'b0, `MASK_TOP}) begin
         t = {1'b0, `MASK_TOP};
      end
      return t;
   endfunction

   // ---------------- Port A low nibble ----------------
   wire logic bus_phase; // Write strobe or address output phase
   wire logic [`PA_PINS-1:0] pa_ddov;
   wire logic [`PA_PINS-1:0] pa_pvov;
   wire logic [`PA_PINS-1:0] pa_puov;
   wire logic [`PA_PINS-1:0] pa_ovr;

   assign bus_phase = write_strobe | address_active;
   assign pa_ovr = {`PA_PINS{ext_mem_enable}};
   assign pa_ddov = {`PA_PINS{bus_phase}};
   // Address while address phase, write data while strobe
   assign pa_pvov = (addr_low & {`PA_PINS{address_active}})
                  | (data_out & {`PA_PINS{write_strobe}});
   // Idle memory pins pull up from port bit, global disable wins
   assign pa_puov = ~pa_ddov & out_a & {`PA_PINS{~global_pullup_disable}};

   pin_override_cell #(.N(`PA_PINS)) port_a_cell (
      .clk(clk),
      .reset_n(reset_n),
      .pullup_override_en(pa_ovr),
      .pullup_override_val(pa_puov),
      .direction_override_en(pa_ovr),
      .direction_override_val(pa_ddov),
      .value_override_en(pa_ovr),
      .value_override_val(pa_pvov),
      .dir_bits(dir_a),
      .out_bits(out_a),
      .global_pullup_disable(global_pullup_disable),
      .pad_in(pad_in_a),
      .pad_out_q(pad_out_a),
      .pad_oe_n_q(pad_oe_n_a),
      .pullup_q(pullup_a),
      .din_q(data_in)
   );

   // ---------------- Port B ----------------
   serial_role_type role; // Current serial role
   wire logic is_slave;
   wire logic is_master;
   wire logic [`PB_PINS-1:0] pb_force_in; // Pins forced to input
   wire logic [`PB_PINS-1:0] pb_value_override_en;
   wire logic [`PB_PINS-1:0] pb_pvov;
   wire logic [`PB_PINS-1:0] pb_puov;
   logic slave_active_q; // Registered slave activity
   wire logic [1:0] unused_comp; // Comparator pins carry no digital function here

   assign role = !serial_if_enable ? role_off
               : (serial_master_select ? role_master : role_slave);
   assign is_slave = (role == role_slave);
   assign is_master = (role == role_master);

   // Role dependent input forcing per pin
   assign pb_force_in = {is_slave, is_master, is_slave, is_slave, 4'h0};
   // Values driven when the direction bit makes the pin an output
   assign pb_value_override_en = {is_master, is_slave, is_master, 4'h0,
                     compare_out_enable};
   assign pb_pvov = {serial_clock_out, slave_data_out, master_data_out, 4'h0,
                     timer_zero_compare_out};
   // Forced inputs still pull up from the port bit
   assign pb_puov = out_b & {`PB_PINS{~global_pullup_disable}};

   pin_override_cell #(.N(`PB_PINS)) port_b_cell (
      .clk(clk),
      .reset_n(reset_n),
      .pullup_override_en(pb_force_in),
      .pullup_override_val(pb_puov),
      .direction_override_en(pb_force_in),
      .direction_override_val({`PB_PINS{1'b0}}),
      .value_override_en(pb_value_override_en),
      .value_override_val(pb_pvov),
      .dir_bits(dir_b),
      .out_bits(out_b),
      .global_pullup_disable(global_pullup_disable),
      .pad_in(pad_in_b),
      .pad_out_q(pad_out_b),
      .pad_oe_n_q(pad_oe_n_b),
      .pullup_q(pullup_b),
      .din_q({serial_clock_in, master_data_in, slave_data_in, slave_select_in,
              unused_comp, timer_one_count_in, timer_zero_count_in})
   );

   // Slave activity follows the select pin, low active
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         slave_active_q <= 1'b0;
      end else begin
         slave_active_q <= is_slave & ~pad_in_b[`PB_SS];
      end
   end
   assign serial_slave_active = slave_active_q;

   // ---------------- Port C ----------------
   wire logic [`PC_PINS-1:0] pc_ovr; // Upper address override per pin

   generate
      for (genvar i = 0; i < `PC_PINS; i++) begin : g_pc
         // Mask below this pin's threshold hands it to the memory bus
         assign pc_ovr[i] = ext_mem_enable
                          & ({1'b0, address_mask_field} < mask_threshold(i));
      end
   endgenerate

   pin_override_cell #(.N(`PC_PINS)) port_c_cell (
      .clk(clk),
      .reset_n(reset_n),
      .pullup_override_en(pc_ovr),
      .pullup_override_val({`PC_PINS{1'b0}}),
      .direction_override_en(pc_ovr),
      .direction_override_val({`PC_PINS{1'b1}}),
      .value_override_en(pc_ovr),
      .value_override_val(addr_high),
      .dir_bits(dir_c),
      .out_bits(out_c),
      .global_pullup_disable(global_pullup_disable),
      .pad_in(pad_in_c),
      .pad_out_q(pad_out_c),
      .pad_oe_n_q(pad_oe_n_c),
      .pullup_q(pullup_c),
      .din_q()
   );

   // ---------------- Checks ----------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_pa_address_out: assert property (
      ext_mem_enable && address_active && !write_strobe
      |=> pad_oe_n_a == '0 && pad_out_a == $past(addr_low))
      else $error("port A does not drive address");
   a_pa_idle_pullup: assert property (
      ext_mem_enable && !bus_phase && !global_pullup_disable
      |=> pad_oe_n_a == '1 && pullup_a == $past(out_a))
      else $error("port A idle pull-up wrong");
   a_sck_slave_in: assert property (
      serial_if_enable && !serial_master_select
      |=> pad_oe_n_b[`PB_SCK]
          && pullup_b[`PB_SCK] == ($past(out_b[`PB_SCK]) & !$past(global_pullup_disable)))
      else $error("clock pin not input as slave");
   a_miso_master_in: assert property (
      serial_if_enable && serial_master_select |=> pad_oe_n_b[`PB_MISO])
      else $error("data-in pin driven as master");
   a_mosi_master_out: assert property (
      serial_if_enable && serial_master_select && dir_b[`PB_MOSI]
      |=> !pad_oe_n_b[`PB_MOSI] && pad_out_b[`PB_MOSI] == $past(master_data_out))
      else $error("master data not on pin");
   a_ss_slave_active: assert property (
      serial_if_enable && !serial_master_select && !pad_in_b[`PB_SS]
      |=> pad_oe_n_b[`PB_SS] && serial_slave_active)
      else $error("slave select handling wrong");
   a_pud_all_off: assert property (
      global_pullup_disable |=> pullup_a == '0 && pullup_b == '0 && pullup_c == '0)
      else $error("pull-up on under global disable");
   a_compare_out: assert property (
      compare_out_enable && dir_b[`PB_TIMER_ZERO]
      |=> !pad_oe_n_b[`PB_TIMER_ZERO]
          && pad_out_b[`PB_TIMER_ZERO] == $past(timer_zero_compare_out))
      else $error("compare output missing");
   a_upper_addr: assert property (
      ext_mem_enable && address_mask_field == '0
      |=> pad_oe_n_c == '0 && pad_out_c == $past(addr_high) && pullup_c == '0)
      else $error("upper address not driven");
   a_upper_mask_top: assert property (
      ext_mem_enable && address_mask_field == `MASK_TOP && !dir_c[0] |=> pad_oe_n_c[0])
      else $error("masked upper pin still driven");

   c_mem_write: cover property (ext_mem_enable && write_strobe ##1 !pad_oe_n_a[0]);
   c_spi_slave: cover property (serial_if_enable && !serial_master_select ##1 serial_slave_active);
   c_spi_master: cover property (serial_if_enable && serial_master_select && dir_b[`PB_SCK]);
   c_mask_partial: cover property (ext_mem_enable && address_mask_field == 3'h4);

endmodule

// ==== rtl/port_override_defs.svh ====
`ifndef PORT_OVERRIDE_DEFS_SVH
`define PORT_OVERRIDE_DEFS_SVH

// Pin counts of the three port slices
`define PA_PINS 4
`define PB_PINS 8
`define PC_PINS 8

// Port B pin positions
`define PB_SCK 7
`define PB_MISO 6
`define PB_MOSI 5
`define PB_SS 4
`define PB_TIMER_ONE 1
`define PB_TIMER_ZERO 0

// Address mask field width and pin thresholds
`define MASK_W 3
`define MASK_TOP 3'h7

// Reset values of the pad side
`define OE_N_RESET 1'b1
`define OUT_RESET 1'b0
`define PULLUP_RESET 1'b0

`endif

// ==== rtl/port_override_pkg.sv ====
package port_override_pkg;

   // Serial interface role seen by the pin logic
   typedef enum logic [1:0] {
      role_off = 2'b00,
      role_slave = 2'b01,
      role_master = 2'b10
   } serial_role_type;

endpackage

// ==== rtl/pin_override_cell.sv ====
`timescale 1ns/100ps
`include "port_override_defs.svh"

// Generic override combine for a group of pins, registered toward the pad
module pin_override_cell #(
   parameter int N = 8
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [N-1:0] pullup_override_en,
   input wire logic [N-1:0] pullup_override_val,
   input wire logic [N-1:0] direction_override_en,
   input wire logic [N-1:0] direction_override_val,
   input wire logic [N-1:0] value_override_en,
   input wire logic [N-1:0] value_override_val,
   input wire logic [N-1:0] dir_bits,
   input wire logic [N-1:0] out_bits,
   input wire logic global_pullup_disable,
   input wire logic [N-1:0] pad_in,
   output logic [N-1:0] pad_out_q,
   output logic [N-1:0] pad_oe_n_q,
   output logic [N-1:0] pullup_q,
   output logic [N-1:0] din_q
);

   // Effective direction, value and pull-up per pin
   wire logic [N-1:0] drive_d;
   wire logic [N-1:0] value_d;
   wire logic [N-1:0] pullup_d;
   wire logic [N-1:0] plain_pullup;

   // Plain pull-up only for input with port bit high and no global disable
   assign plain_pullup = ~dir_bits & out_bits & {N{~global_pullup_disable}};
   assign drive_d = (direction_override_en & direction_override_val)
                  | (~direction_override_en & dir_bits);
   assign value_d = (value_override_en & value_override_val)
                  | (~value_override_en & out_bits);
   assign pullup_d = ((pullup_override_en & pullup_override_val)
                   | (~pullup_override_en & plain_pullup)) & ~drive_d;

   // Pad registers; output enable is active low
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pad_out_q <= {N{`OUT_RESET}};
         pad_oe_n_q <= {N{`OE_N_RESET}};
         pullup_q <= {N{`PULLUP_RESET}};
         din_q <= '0;
      end else begin
         pad_out_q <= value_d & drive_d;
         pad_oe_n_q <= ~drive_d;
         pullup_q <= pullup_d;
         din_q <= pad_in;
      end
   end

endmodule

// ==== dv/pad_world.sv ====
`timescale 1ns/100ps
// Far side of one port: outside parts drive released pins, else pull-up or float
module pad_world #(
   parameter int N = 8
) (
   input wire logic clk,
   input wire logic [N-1:0] pad_out,
   input wire logic [N-1:0] pad_oe_n,
   input wire logic [N-1:0] pull_en,
   input wire logic [N-1:0] ext_val,
   input wire logic [N-1:0] ext_en,
   output logic [N-1:0] pad_in
);
   logic float_q = 1'b0; // Changing level of an undriven, unpulled wire
   wire [N-1:0] ext_on = pad_oe_n & ext_en; // Outside part yields to the block
   wire [N-1:0] idle = pad_oe_n & ~ext_en; // Nobody drives the wire
   // Wire level; an outside master pulling select low wakes the slave
   assign pad_in = (~pad_oe_n & pad_out) | (ext_on & ext_val) | (idle & pull_en)
      | (idle & ~pull_en & {N{float_q}});
   // Float pattern flips every cycle so a stale level never passes
   always_ff @(posedge clk) begin
      float_q <= ~float_q;
   end
endmodule

// ==== dv/test_port_alternate_function_override.sv ====
`timescale 1ns/100ps
// Random pin traffic checked against a per-cycle reference of the override logic
module test_port_alternate_function_override;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic global_pullup_disable, ext_mem_enable, address_active, write_strobe;
   logic serial_if_enable, serial_master_select, serial_clock_out, master_data_out;
   logic slave_data_out, compare_out_enable, timer_zero_compare_out;
   logic serial_clock_in, master_data_in, slave_data_in, slave_select_in;
   logic serial_slave_active, timer_one_count_in, timer_zero_count_in;
   logic [2:0] address_mask_field;
   logic [3:0] addr_low, data_out, dir_a, out_a, pad_in_a, pad_out_a, pad_oe_n_a, pullup_a;
   logic [3:0] data_in, ext_val_a, ext_en_a;
   logic [7:0] addr_high, dir_b, out_b, pad_in_b, pad_out_b, pad_oe_n_b, pullup_b;
   logic [7:0] dir_c, out_c, pad_in_c, pad_out_c, pad_oe_n_c, pullup_c;
   logic [7:0] ext_val_b, ext_en_b, ext_val_c, ext_en_c;
   logic [31:0] seed = 32'h000125d6; // Random source state
   logic [3:0][31:0] exp_q[$]; // Results promised for the next edge
   int n_fail = 0;
   int n_compared = 0;
   int cyc = 0;
   int mode = 0; // 0 plain, 1 memory, 2 slave, 3 master, 4 mixed
   wire [6:0] peri_in = {serial_clock_in, master_data_in, slave_data_in, slave_select_in,
      serial_slave_active, timer_one_count_in, timer_zero_count_in};

   port_alternate_function_override u_port_alternate_function_override (
      .clk, .reset_n, .global_pullup_disable, .ext_mem_enable, .address_active,
      .write_strobe, .address_mask_field, .addr_low, .data_out, .addr_high, .dir_a, .out_a,
      .pad_in_a, .pad_out_a, .pad_oe_n_a, .pullup_a, .data_in, .serial_if_enable,
      .serial_master_select, .serial_clock_out, .master_data_out, .slave_data_out,
      .compare_out_enable, .timer_zero_compare_out, .dir_b, .out_b, .pad_in_b, .pad_out_b,
      .pad_oe_n_b, .pullup_b, .serial_clock_in, .master_data_in, .slave_data_in,
      .slave_select_in, .serial_slave_active, .timer_one_count_in, .timer_zero_count_in,
      .dir_c, .out_c, .pad_in_c, .pad_out_c, .pad_oe_n_c, .pullup_c
   );
   pad_world #(.N(4)) world_a (.clk, .pad_out(pad_out_a), .pad_oe_n(pad_oe_n_a),
      .pull_en(pullup_a), .ext_val(ext_val_a), .ext_en(ext_en_a), .pad_in(pad_in_a));
   pad_world #(.N(8)) world_b (.clk, .pad_out(pad_out_b), .pad_oe_n(pad_oe_n_b),
      .pull_en(pullup_b), .ext_val(ext_val_b), .ext_en(ext_en_b), .pad_in(pad_in_b));
   pad_world #(.N(8)) world_c (.clk, .pad_out(pad_out_c), .pad_oe_n(pad_oe_n_c),
      .pull_en(pullup_c), .ext_val(ext_val_c), .ext_en(ext_en_c), .pad_in(pad_in_c));

   // Free-running clock
   always #5 clk = ~clk;

   // Galois shift step of the random source
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return s[0] ? (s >> 1) ^ 32'h80200003 : s >> 1;
   endfunction

   // Compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      n_compared++;
      if (seen !== want) begin
         n_fail++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, want);
      end
   endtask

   // Counts, verdict, end of run
   task automatic print_verdict();
      $display("compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // New random inputs, shaped by the current mode
   task automatic drive();
      logic [127:0] r;
      for (int i = 0; i < 128; i++) begin
         seed = lfsr_next(seed);
         r = {r[126:0], seed[0]};
      end
      {global_pullup_disable, addr_high, addr_low, data_out, dir_a, out_a, serial_clock_out,
       master_data_out, slave_data_out, timer_zero_compare_out, dir_c, out_c, ext_val_a,
       ext_en_a, ext_val_b, ext_en_b, ext_val_c, ext_en_c, compare_out_enable,
       address_active} <= r[86:0];
      write_strobe <= r[93] & ~r[0];
      ext_mem_enable <= (mode == 1) || (mode > 1 && r[90]);
      serial_if_enable <= (mode == 2) || (mode == 3) || (mode == 4 && r[91]);
      serial_master_select <= (mode == 3) || (mode == 4 && r[92]);
      address_mask_field <= (mode == 1) ? cyc[2:0] : r[89:87];
      out_b <= r[109:102] & 8'hf3;
      dir_b <= (r[101:94] & 8'hf3) | {7'h00, r[1]};
   endtask

   initial drive();
   always @(posedge clk) drive();

   // Reference: check what was promised, then work out the next promise
   always @(posedge clk) begin : reference
      logic [3:0][31:0] e;
      logic [3:0] da, va;
      logic [7:0] db, vb, fb, dc, vc, oc;
      logic slv, mst, pd;
      if (exp_q.size() > 0) begin
         e = exp_q.pop_front();
         check(32'({pad_out_a, pad_oe_n_a, pullup_a, data_in}), e[0]);
         check(32'({pad_out_b, pad_oe_n_b, pullup_b}), e[1]);
         check(32'(peri_in), e[2]);
         check(32'({pad_out_c, pad_oe_n_c, pullup_c}), e[3]);
      end
      pd = global_pullup_disable;
      da = ext_mem_enable ? {4{write_strobe | address_active}} : dir_a;
      va = ext_mem_enable ? (addr_low & {4{address_active}}) | (data_out & {4{write_strobe}})
         : out_a;
      slv = serial_if_enable & ~serial_master_select;
      mst = serial_if_enable & serial_master_select;
      fb = slv ? 8'hb0 : {1'b0, mst, 6'h00};
      db = dir_b & ~fb;
      vb = {mst ? serial_clock_out : out_b[7], slv ? slave_data_out : out_b[6],
         mst ? master_data_out : out_b[5], out_b[4:1],
         compare_out_enable ? timer_zero_compare_out : out_b[0]};
      for (int i = 0; i < 8; i++) begin
         oc[i] = ext_mem_enable && (address_mask_field < ((i == 0) ? 7 : 8 - i));
      end
      dc = oc | dir_c;
      vc = (addr_high & oc) | (out_c & ~oc);
      e[0] = 32'({va & da, ~da, ~da & out_a & {4{~pd}}, pad_in_a});
      e[1] = 32'({vb & db, ~db, ~db & out_b & {8{~pd}}});
      e[2] = 32'({pad_in_b[7:4], slv & ~pad_in_b[4], pad_in_b[1:0]});
      e[3] = 32'({vc & dc, ~dc, ~dc & out_c & {8{~pd}}});
      if (!reset_n) begin
         e = {32'h0000ff00, 32'h00000000, 32'h0000ff00, 32'h00000f00};
      end
      exp_q.push_back(e);
   end

   // Cycle count with a ceiling well past the planned run
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         n_fail++;
         print_verdict();
      end
   end

   // Main sequence: reset, then one phase per mode, last with a reset in mid-run
   initial begin
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      for (int m = 0; m < 5; m++) begin
         mode <= m;
         repeat (400) @(posedge clk);
         if (m == 4) begin
            reset_n <= 1'b0;
            repeat (3) @(posedge clk);
            reset_n <= 1'b1;
            repeat (50) @(posedge clk);
         end
         $display("test %0d done, %0d mismatches so far", m, n_fail);
      end
      print_verdict();
   end
endmodule
